//--- irq_ctrl_regs.vh
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// Vector slot addresses
`define VEC_RESET     8'h04
`define VEC_SYS_EXC   8'h08
`define VEC_RESERVED  8'h0c
`define VEC_FIRST_SRC 8'h10
`define VEC_STRIDE    8'h04

// Width of a presented slot address
`define VEC_W         8

// Programmable sources and their indices
`define NUM_SRC       24
`define SRC_IDX_W     5
`define SRC_PORT7     5'h08
`define SRC_PORT0     5'h0f
`define SRC_PORTC3    5'h14

// Priority level field width; level 0 keeps a source out
`define PRIO_W        2

// Service address byte order inside a 4-byte entry
`define VEC_BYTE_HI   2'h1
`define VEC_BYTE_LO   2'h3

`endif

//--- pin_edge_sync.v
`timescale 1ns/1ns
module pin_edge_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  // Raw pins and edge pulses
  input  wire [W-1:0] pin,
  output reg  [W-1:0] rise_q,
  output reg  [W-1:0] fall_q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;
  wire [W-1:0] agree;
  wire [W-1:0] lvl_d;

  // A change counts only once the second and third stages agree
  assign agree = ~(s2_q ^ s3_q);
  assign lvl_d = (agree & s3_q) | (~agree & lvl_q);

  always @(posedge clk) begin
    if (sys_rst) begin
      s1_q   <= {W{1'b0}};
      s2_q   <= {W{1'b0}};
      s3_q   <= {W{1'b0}};
      lvl_q  <= {W{1'b0}};
      rise_q <= {W{1'b0}};
      fall_q <= {W{1'b0}};
    end else begin
      s1_q   <= pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      rise_q <= lvl_d & ~lvl_q;
      fall_q <= ~lvl_d & lvl_q;
    end
  end

endmodule

//--- vectored_priority_interrupt_ctrl.v
`timescale 1ns/1ns
`include "irq_ctrl_regs.vh"

module vectored_priority_interrupt_ctrl (
  // Clock and reset
  input  wire                          clk,
  input  wire                          sys_rst,
  // Peripheral pulses: 0..7 timers..converter, 8..11 pwm..pwm fault
  input  wire [11:0]                   periph_pulse,
  input  wire [3:0]                    dma_pulse,
  input  wire                          on_chip_debugger_request,
  input  wire                          sys_exc_pulse,
  // Pins from outside the clock domain
  input  wire [7:0]                    port_a_pin,
  input  wire [7:0]                    port_d_pin,
  input  wire [3:0]                    port_c_pin,
  input  wire                          cmp_out,
  // Configuration levels
  input  wire [7:0]                    pin_sel_d,
  input  wire [7:0]                    pin_edge_rise,
  input  wire                          cmp_sel,
  input  wire                          dbg_sel,
  input  wire [3:0]                    portc_sel_pin,
  input  wire [`NUM_SRC*`PRIO_W-1:0]   src_level,
  input  wire                          vectored_mode,
  // Software request control, one-cycle pulses
  input  wire [`NUM_SRC-1:0]           sw_set,
  input  wire [`NUM_SRC-1:0]           sw_clear,
  input  wire                          enable_set,
  input  wire                          enable_clear,
  // Processor handshake
  input  wire                          cpu_ack,
  output reg                           irq_valid_q,
  output reg  [`VEC_W-1:0]             vec_addr_q,
  output reg  [`NUM_SRC-1:0]           req_q,
  output reg                           global_irq_enable_flag_q
);

  wire [7:0] a_rise;
  wire [7:0] a_fall;
  wire [7:0] d_rise;
  wire [7:0] d_fall;
  wire [3:0] c_rise;
  wire [3:0] c_fall;
  wire       k_rise;
  wire       k_fall;

  pin_edge_sync #(.W(21)) u_pins (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     ({cmp_out, port_c_pin, port_d_pin, port_a_pin}),
    .rise_q  ({k_rise, c_rise, d_rise, a_rise}),
    .fall_q  ({k_fall, c_fall, d_fall, a_fall})
  );

  reg [`NUM_SRC-1:0]   hw_set;
  reg [7:0]            pin_evt;
  reg                  pin_r;
  reg                  pin_f;
  integer              b;

  // Hardware request pulses per slot
  always @* begin
    hw_set  = {`NUM_SRC{1'b0}};
    pin_evt = 8'h00;
    for (b = 0; b < 8; b = b + 1) begin
      pin_r      = pin_sel_d[b] ? d_rise[b] : a_rise[b];
      pin_f      = pin_sel_d[b] ? d_fall[b] : a_fall[b];
      pin_evt[b] = pin_edge_rise[b] ? pin_r : pin_f;
    end
    hw_set[7:0] = periph_pulse[7:0];
    hw_set[`SRC_PORT7] = cmp_sel ? (k_rise | k_fall) : pin_evt[7];
    for (b = 1; b < 7; b = b + 1) begin
      hw_set[`SRC_PORT7 + 7 - b] = pin_evt[b];
    end
    hw_set[`SRC_PORT0] = dbg_sel ? on_chip_debugger_request
                                 : pin_evt[0];
    hw_set[19:16] = periph_pulse[11:8];
    for (b = 0; b < 4; b = b + 1) begin
      hw_set[`SRC_PORTC3 + 3 - b] = portc_sel_pin[b]
                                    ? (c_rise[b] | c_fall[b])
                                    : dma_pulse[b];
    end
  end

  // Arbitration: highest level first, then lowest slot index
  reg [`PRIO_W-1:0]    best_lvl;
  reg [`SRC_IDX_W-1:0] best_idx;
  reg [`PRIO_W-1:0]    lvl;
  integer              i;

  always @* begin
    best_lvl = {`PRIO_W{1'b0}};
    best_idx = {`SRC_IDX_W{1'b0}};
    lvl      = {`PRIO_W{1'b0}};
    for (i = `NUM_SRC - 1; i >= 0; i = i - 1) begin
      lvl = src_level[i*`PRIO_W +: `PRIO_W];
      if (req_q[i] && lvl != 2'h0 && lvl >= best_lvl) begin
        best_lvl = lvl;
        best_idx = i[`SRC_IDX_W-1:0];
      end
    end
  end

  reg                  rst_pend_q;
  reg                  exc_pend_q;
  reg                  sel_src_q;
  reg [`SRC_IDX_W-1:0] sel_idx_q;
  wire                 mask_ok;
  wire                 take;
  wire                 acked;
  wire [`VEC_W-1:0]    src_vec;
  reg  [`NUM_SRC-1:0]  ack_clr;

  // Polled mode keeps maskable requests away from the processor
  assign mask_ok = vectored_mode && global_irq_enable_flag_q
                   && best_lvl != 2'h0;
  assign take    = !irq_valid_q && (rst_pend_q || exc_pend_q || mask_ok);
  assign acked   = irq_valid_q && cpu_ack;
  // Slots are 4 bytes apart so the address low bits stay zero
  assign src_vec = `VEC_FIRST_SRC
                   + {1'b0, best_idx, 2'b00};

  always @* begin
    ack_clr = {`NUM_SRC{1'b0}};
    if (acked && sel_src_q) begin
      ack_clr[sel_idx_q] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      req_q                    <= {`NUM_SRC{1'b0}};
      global_irq_enable_flag_q <= 1'b0;
      rst_pend_q               <= 1'b1;
      exc_pend_q               <= 1'b0;
      irq_valid_q              <= 1'b0;
      vec_addr_q               <= {`VEC_W{1'b0}};
      sel_src_q                <= 1'b0;
      sel_idx_q                <= {`SRC_IDX_W{1'b0}};
    end else begin
      // A new pulse in the clearing cycle survives
      req_q <= (req_q & ~sw_clear & ~ack_clr)
               | hw_set | sw_set;
      if (acked && sel_src_q) begin
        global_irq_enable_flag_q <= 1'b0;
      end else if (enable_set) begin
        global_irq_enable_flag_q <= 1'b1;
      end else if (enable_clear) begin
        global_irq_enable_flag_q <= 1'b0;
      end
      if (sys_exc_pulse) begin
        exc_pend_q <= 1'b1;
      end else if (acked && !sel_src_q && vec_addr_q == `VEC_SYS_EXC) begin
        exc_pend_q <= 1'b0;
      end
      if (acked && vec_addr_q == `VEC_RESET) begin
        rst_pend_q <= 1'b0;
      end
      if (take) begin
        irq_valid_q <= 1'b1;
        if (rst_pend_q) begin
          vec_addr_q <= `VEC_RESET;
          sel_src_q  <= 1'b0;
        end else if (exc_pend_q) begin
          vec_addr_q <= `VEC_SYS_EXC;
          sel_src_q  <= 1'b0;
        end else begin
          vec_addr_q <= src_vec;
          sel_src_q  <= 1'b1;
          sel_idx_q  <= best_idx;
        end
      end else if (acked) begin
        irq_valid_q <= 1'b0;
      end
    end
  end

endmodule

//--- vpic_sva.sv
`timescale 1ns/1ns
module vpic_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Requests
  input wire logic        sys_exc_pulse,
  input wire logic [23:0] sw_set,
  input wire logic        enable_set,
  input wire logic        vectored_mode,
  // Processor side
  input wire logic        cpu_ack,
  input wire logic        irq_valid_q,
  input wire logic [7:0]  vec_addr_q,
  input wire logic [23:0] req_q,
  input wire logic        global_irq_enable_flag_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  hold_vec_a: assert property (irq_valid_q && !cpu_ack |=> irq_valid_q && $stable(vec_addr_q)) else $error("vector moved before ack");
  drop_valid_a: assert property (irq_valid_q && cpu_ack |=> !irq_valid_q) else $error("valid kept after ack");
  sw_latch_a: assert property (|sw_set |=> (req_q & $past(sw_set)) == $past(sw_set)) else $error("flag not latched");
  ack_disable_a: assert property (irq_valid_q && cpu_ack && vec_addr_q > 8'h0c |=> !global_irq_enable_flag_q) else $error("enable kept");
  en_set_a: assert property (enable_set && !(irq_valid_q && cpu_ack) |=> global_irq_enable_flag_q) else $error("enable not set");
  exc_vec_a: assert property (sys_exc_pulse |-> ##[2:60] irq_valid_q && vec_addr_q == 8'h08) else $error("exception lost");
  gate_mask_a: assert property ($rose(irq_valid_q) && vec_addr_q > 8'h0c |-> $past(global_irq_enable_flag_q) && $past(vectored_mode)) else $error("masked request shown");
  slot_ok_a: assert property (irq_valid_q |-> vec_addr_q[1:0] == 2'h0 && vec_addr_q != 8'h0c && vec_addr_q inside {[8'h04:8'h6c]}) else $error("bad slot");
  rst_vec_a: assert property ($fell(sys_rst) |=> irq_valid_q && vec_addr_q == 8'h04) else $error("no reset vector");
endmodule

//--- cpu_model.sv
`timescale 1ns/1ns
module cpu_model (
  input  wire logic       clk,
  input  wire logic [3:0] dly,
  input  wire logic       irq_valid_q,
  output logic            cpu_ack
);
  logic [3:0] cnt_q;
  initial cpu_ack = 0;
  // One-cycle acknowledge after a chosen think time
  always @(posedge clk) begin
    if (!irq_valid_q || cpu_ack) begin
      cnt_q <= 0;
      cpu_ack <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
      cpu_ack <= (cnt_q >= dly);
    end
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ns
module testbench;
  logic clk = 0, sys_rst = 1, sys_exc_pulse = 0, cmp_out = 0, cmp_sel = 0;
  logic dbg_sel = 0, on_chip_debugger_request = 0, vectored_mode = 1;
  logic enable_set = 0, enable_clear = 0, cpu_ack, irq_valid_q;
  logic global_irq_enable_flag_q;
  logic [3:0] dma_pulse = 0, port_c_pin = 0, portc_sel_pin = 0, dly = 1;
  logic [7:0] port_a_pin = 0, port_d_pin = 0, pin_sel_d = 0, vec_addr_q;
  logic [7:0] pin_edge_rise = 8'hff;
  logic [11:0] periph_pulse = 0;
  logic [47:0] src_level = 0;
  logic [23:0] sw_set = 0, sw_clear = 0, req_q;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  vectored_priority_interrupt_ctrl DUT (.*);
  cpu_model cpu (.*);
  initial forever #5 clk = ~clk;
  task check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task serve(input logic [7:0] v);
    int n;
    n = 0;
    while (irq_valid_q !== 1 && n < 50) begin
      @(posedge clk) #1 n++;
    end
    check(vec_addr_q, v);
    while (irq_valid_q === 1 && n < 80) begin
      @(posedge clk) #1 n++;
    end
  endtask
  task en;
    @(posedge clk) enable_set <= 1;
    @(posedge clk) enable_set <= 0;
  endtask
  task t_prio;
    // Slot 0x24 at level 3, 0x38 at level 2, 0x1c at level 1
    @(posedge clk) src_level <= 48'h000000_200c40;
    @(posedge clk) sw_set <= 24'h000428;
    @(posedge clk) sw_set <= 0;
    en;
    serve(8'h24);
    check(global_irq_enable_flag_q, 0);
    en;
    serve(8'h38);
    en;
    serve(8'h1c);
    check(req_q, 0);
  endtask
  task t_poll;
    // Slot 0x10 eligible, so only polled mode keeps it away
    @(posedge clk) begin
      vectored_mode <= 0;
      src_level[1:0] <= 2'h3;
    end
    en;
    @(posedge clk) sw_set <= 24'h1;
    @(posedge clk) sw_set <= 0;
    repeat (10) @(posedge clk);
    #1 check({req_q[0], irq_valid_q}, 2'h2);
    @(posedge clk) sw_clear <= 24'h1;
    @(posedge clk) sw_clear <= 0;
    #1 check(req_q[0], 0);
    vectored_mode <= 1;
  endtask
  task t_exc;
    @(posedge clk) enable_clear <= 1;
    @(posedge clk) {enable_clear, sys_exc_pulse} <= 2'h1;
    @(posedge clk) sys_exc_pulse <= 0;
    serve(8'h08);
  endtask
  task t_src;
    dly <= 6;
    src_level[47:32] <= 16'h8001;
    src_level[19:18] <= 1;
    @(posedge clk) {periph_pulse[8], dma_pulse[0]} <= 2'h3;
    port_a_pin[6] <= 1;
    @(posedge clk) {periph_pulse[8], dma_pulse[0]} <= 0;
    repeat (8) @(posedge clk);
    #1 check(req_q, 24'h810200);
    en;
    serve(8'h6c);
    en;
    serve(8'h34);
    en;
    serve(8'h50);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    serve(8'h04);
    check(req_q, 0);
    t_prio;
    t_poll;
    t_exc;
    t_src;
    conclude;
  end
endmodule
bind vectored_priority_interrupt_ctrl vpic_chk chk (.*);
